/* File: pkg/ebac_pkg.sv */
// package: constants for the nonvolatile byte access controller
package ebac_pkg;
  localparam int          ADDR_W        = 9;
  localparam int          DEPTH         = 512;
  localparam logic [11:0] OFF_ADDR_LO   = 12'h000;
  localparam logic [11:0] OFF_ADDR_HI   = 12'h004;
  localparam logic [11:0] OFF_DATA      = 12'h008;
  localparam logic [11:0] OFF_CTRL      = 12'h00C;
  localparam logic [11:0] OFF_STALL     = 12'h010;
  localparam int          CTRL_READ     = 0;
  localparam int          CTRL_START    = 1;
  localparam int          CTRL_ARM      = 2;
  localparam int          CTRL_MODE_LO  = 4;
  localparam logic [1:0]  MODE_ATOMIC   = 2'h0;
  localparam logic [1:0]  MODE_ERASE    = 2'h1;
  localparam logic [1:0]  MODE_WRITE    = 2'h2;
  localparam logic [1:0]  MODE_RESV     = 2'h3;
  localparam logic [2:0]  ARM_CYCLES    = 3'h4;
  localparam logic [2:0]  READ_STALL    = 3'h4;
  localparam logic [2:0]  WRITE_STALL   = 3'h2;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam int          CLK_HZ        = 250000000;
  localparam int          OSC_HZ        = 8000000;
  localparam int          OSC_DIV       = CLK_HZ / OSC_HZ;
  localparam int          T_ATOMIC_US   = 3400;
  localparam int          T_SPLIT_US    = 1800;
  localparam int          ATOMIC_TICKS  = T_ATOMIC_US * (OSC_HZ / 1000000);
  localparam int          SPLIT_TICKS   = T_SPLIT_US * (OSC_HZ / 1000000);
endpackage : ebac_pkg

/* File: rtl/ebac_mem.sv */
// byte-wide storage array with registered read data
`timescale 1ns/100ps
`default_nettype none
module ebac_mem (
  input  wire logic                       clk,
  input  wire logic                       we,
  input  wire logic [ebac_pkg::ADDR_W-1:0] waddr,
  input  wire logic [7:0]                 wdata,
  input  wire logic [ebac_pkg::ADDR_W-1:0] raddr,
  output var  logic [7:0]                 rdata
);
  logic [7:0] mem_reg [0:ebac_pkg::DEPTH-1];

  // no reset: content stands for nonvolatile cells
  always_ff @(posedge clk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
    rdata <= mem_reg[raddr];
  end
endmodule : ebac_mem
`default_nettype wire

/* File: rtl/ebac_ctrl.sv */
// byte access controller: AXI4-Lite registers, arming, timed programming
`timescale 1ns/100ps
`default_nettype none
module ebac_ctrl #(
  parameter int ATOMIC_TICKS = ebac_pkg::ATOMIC_TICKS,
  parameter int SPLIT_TICKS  = ebac_pkg::SPLIT_TICKS,
  parameter int OSC_DIV      = ebac_pkg::OSC_DIV
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output var  logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output var  logic        S_AXI_WREADY,
  output var  logic [1:0]  S_AXI_BRESP,
  output var  logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output var  logic        S_AXI_ARREADY,
  output var  logic [31:0] S_AXI_RDATA,
  output var  logic [1:0]  S_AXI_RRESP,
  output var  logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output var  logic        CPU_STALL,
  output var  logic        NV_BUSY
);
  typedef enum logic [2:0] {
    PS_IDLE  = 3'b001,
    PS_ERASE = 3'b010,
    PS_WRITE = 3'b100
  } ebac_pst_t;

  typedef struct packed {
    logic                        aw_got;
    logic [11:0]                 aw_addr;
    logic                        w_got;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    logic [ebac_pkg::ADDR_W-1:0] nv_address_reg;
    logic [7:0]                  nv_data_reg;
    logic [1:0]                  program_mode_field;
    logic                        master_program_arm;
    logic [2:0]                  arm_cnt;
    logic                        program_start_bit;
    ebac_pst_t                   pstate;
    logic [ebac_pkg::ADDR_W-1:0] prog_addr;
    logic [7:0]                  prog_data;
    logic [1:0]                  prog_mode;
    logic [22:0]                 tick_cnt;
    logic [7:0]                  div_cnt;
    logic [2:0]                  stall_cnt;
    logic                        rd_pend;
    logic                        awready, wready, arready, stall;
  } ebac_st_t;

  ebac_st_t   st_reg;
  ebac_st_t   st_next;
  logic [7:0] mem_rdata;
  logic       mem_we;
  logic [7:0] mem_wdata;
  logic       osc_tick;

  // merges byte lanes of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] ctrl_word(input ebac_st_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ebac_pkg::CTRL_START] = s.program_start_bit;
    w[ebac_pkg::CTRL_ARM] = s.master_program_arm;
    w[ebac_pkg::CTRL_MODE_LO +: 2] = s.program_mode_field;
    return w;
  endfunction : ctrl_word

  ebac_mem u_mem (
    .clk   (CLK),
    .we    (mem_we),
    .waddr (st_reg.prog_addr),
    .wdata (mem_wdata),
    .raddr (st_reg.program_start_bit ? st_reg.prog_addr :
            st_reg.nv_address_reg),
    .rdata (mem_rdata)
  );

  // erase leaves all ones; write-only can only clear bits, so an
  // unerased target ends up as an AND of old and new
  assign osc_tick = (st_reg.div_cnt == 8'(OSC_DIV - 1));

  always_comb begin
    logic [31:0] wv;
    logic        busy;
    st_next   = st_reg;
    mem_we    = 1'b0;
    mem_wdata = ebac_pkg::ERASED_BYTE;
    wv        = 32'h0000_0000;
    busy      = st_reg.program_start_bit;
    st_next.div_cnt = osc_tick ? 8'h00 : st_reg.div_cnt + 8'h01;

    if (st_reg.stall_cnt != 3'h0) begin
      st_next.stall_cnt = st_reg.stall_cnt - 3'h1;
    end
    if (st_reg.master_program_arm) begin
      if (st_reg.arm_cnt == 3'h1) begin
        st_next.master_program_arm = 1'b0;
      end
      st_next.arm_cnt = st_reg.arm_cnt - 3'h1;
    end
    if (st_reg.rd_pend) begin
      st_next.rd_pend = 1'b0;
      st_next.nv_data_reg = mem_rdata;
    end

    // programming sequencer timed by oscillator ticks
    unique case (st_reg.pstate)
      PS_IDLE: begin
      end
      PS_ERASE: begin
        if (osc_tick) begin
          if (st_reg.tick_cnt == 23'h1) begin
            mem_we = 1'b1;
            mem_wdata = ebac_pkg::ERASED_BYTE;
            if (st_reg.prog_mode == ebac_pkg::MODE_ATOMIC) begin
              st_next.pstate = PS_WRITE;
              st_next.tick_cnt = 23'(ATOMIC_TICKS - SPLIT_TICKS);
            end else begin
              st_next.pstate = PS_IDLE;
              st_next.program_start_bit = 1'b0;
            end
          end else begin
            st_next.tick_cnt = st_reg.tick_cnt - 23'h1;
          end
        end
      end
      PS_WRITE: begin
        if (osc_tick) begin
          if (st_reg.tick_cnt == 23'h1) begin
            mem_we = 1'b1;
            mem_wdata = (st_reg.prog_mode == ebac_pkg::MODE_ATOMIC) ?
                        st_reg.prog_data : (mem_rdata & st_reg.prog_data);
            st_next.pstate = PS_IDLE;
            st_next.program_start_bit = 1'b0;
          end else begin
            st_next.tick_cnt = st_reg.tick_cnt - 23'h1;
          end
        end
      end
    endcase

    // write channel: address and data taken in either order
    if (S_AXI_AWVALID && !st_reg.aw_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !st_reg.w_got && !st_reg.bvalid) begin
      st_next.w_got = 1'b1;
      st_next.w_data = S_AXI_WDATA;
      st_next.w_strb = S_AXI_WSTRB;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = ebac_pkg::RESP_OKAY;
      unique case ({st_reg.aw_addr[11:2], 2'b00})
        ebac_pkg::OFF_ADDR_LO: begin
          if (st_reg.w_strb[0]) begin
            st_next.nv_address_reg[7:0] = st_reg.w_data[7:0];
          end
        end
        ebac_pkg::OFF_ADDR_HI: begin
          if (st_reg.w_strb[0]) begin
            st_next.nv_address_reg[8] = st_reg.w_data[0];
          end
        end
        ebac_pkg::OFF_DATA: begin
          if (st_reg.w_strb[0]) begin
            st_next.nv_data_reg = st_reg.w_data[7:0];
          end
        end
        ebac_pkg::OFF_CTRL: begin
          wv = merge(ctrl_word(st_reg), st_reg.w_data, st_reg.w_strb);
          if (!busy) begin
            st_next.program_mode_field = wv[ebac_pkg::CTRL_MODE_LO +: 2];
          end
          if (wv[ebac_pkg::CTRL_ARM] && !st_reg.master_program_arm) begin
            st_next.master_program_arm = 1'b1;
            st_next.arm_cnt = ebac_pkg::ARM_CYCLES;
          end
          // mode for this start is the field before this same write
          if (wv[ebac_pkg::CTRL_START] && !busy &&
              st_reg.master_program_arm &&
              st_reg.program_mode_field != ebac_pkg::MODE_RESV) begin
            st_next.program_start_bit = 1'b1;
            st_next.master_program_arm = 1'b0;
            st_next.prog_addr = st_reg.nv_address_reg;
            st_next.prog_data = st_reg.nv_data_reg;
            st_next.prog_mode = st_reg.program_mode_field;
            st_next.stall_cnt = ebac_pkg::WRITE_STALL;
            st_next.tick_cnt = 23'(SPLIT_TICKS);
            st_next.pstate = (st_reg.program_mode_field ==
                              ebac_pkg::MODE_WRITE) ? PS_WRITE : PS_ERASE;
          end else if (wv[ebac_pkg::CTRL_READ] && !busy) begin
            st_next.rd_pend = 1'b1;
            st_next.stall_cnt = ebac_pkg::READ_STALL;
          end
        end
        default: st_next.bresp = ebac_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && S_AXI_BREADY) begin
      st_next.bvalid = 1'b0;
    end

    // read channel
    if (S_AXI_ARVALID && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = ebac_pkg::RESP_OKAY;
      unique case ({S_AXI_ARADDR[11:2], 2'b00})
        ebac_pkg::OFF_ADDR_LO:
          st_next.rdata = {24'h0, st_reg.nv_address_reg[7:0]};
        ebac_pkg::OFF_ADDR_HI:
          st_next.rdata = {31'h0, st_reg.nv_address_reg[8]};
        ebac_pkg::OFF_DATA:    st_next.rdata = {24'h0, st_reg.nv_data_reg};
        ebac_pkg::OFF_CTRL:    st_next.rdata = ctrl_word(st_reg);
        ebac_pkg::OFF_STALL:   st_next.rdata = {29'h0, st_reg.stall_cnt};
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = ebac_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rvalid && S_AXI_RREADY) begin
      st_next.rvalid = 1'b0;
    end
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready = !st_next.w_got && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
    st_next.stall = (st_next.stall_cnt != 3'h0);
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_reg <= '0;
      st_reg.pstate <= PS_IDLE;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      if (st_reg.program_start_bit) begin
        // programming under way runs on to its end, mode kept
        st_reg.program_start_bit <= st_next.program_start_bit;
        st_reg.pstate <= st_next.pstate;
        st_reg.program_mode_field <= st_reg.program_mode_field;
        st_reg.prog_addr <= st_reg.prog_addr;
        st_reg.prog_data <= st_reg.prog_data;
        st_reg.prog_mode <= st_reg.prog_mode;
        st_reg.tick_cnt <= st_next.tick_cnt;
        st_reg.div_cnt <= st_next.div_cnt;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign S_AXI_AWREADY = st_reg.awready;
  assign S_AXI_WREADY  = st_reg.wready;
  assign S_AXI_BVALID  = st_reg.bvalid;
  assign S_AXI_BRESP   = st_reg.bresp;
  assign S_AXI_ARREADY = st_reg.arready;
  assign S_AXI_RVALID  = st_reg.rvalid;
  assign S_AXI_RDATA   = st_reg.rdata;
  assign S_AXI_RRESP   = st_reg.rresp;
  assign CPU_STALL     = st_reg.stall;
  assign NV_BUSY       = st_reg.program_start_bit;

  a_arm_expires: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(st_reg.master_program_arm) |-> ##[1:4] !st_reg.master_program_arm)
    else $error("arm bit outlived its window");
  a_read_stall: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(st_reg.rd_pend) |-> CPU_STALL [*4] ##1 !CPU_STALL)
    else $error("read stall not four cycles");
  a_write_stall: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(st_reg.program_start_bit) |-> CPU_STALL [*2] ##1 !CPU_STALL)
    else $error("write stall not two cycles");
  a_mode_frozen: assert property (@(posedge CLK) disable iff (!RST_B)
    st_reg.program_start_bit && $past(st_reg.program_start_bit) |->
    $stable(st_reg.program_mode_field))
    else $error("mode changed while busy");
  a_busy_tracks: assert property (@(posedge CLK) disable iff (!RST_B)
    (st_reg.pstate == PS_IDLE) == !st_reg.program_start_bit)
    else $error("start bit and sequencer disagree");
  a_no_read_busy: assert property (@(posedge CLK) disable iff (!RST_B)
    $past(st_reg.program_start_bit) |-> !$rose(st_reg.rd_pend))
    else $error("read started while busy");
  a_start_armed: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(st_reg.program_start_bit) |-> $past(st_reg.master_program_arm))
    else $error("start without arm");
  a_no_resv: assert property (@(posedge CLK) disable iff (!RST_B)
    st_reg.program_start_bit |-> st_reg.prog_mode != ebac_pkg::MODE_RESV)
    else $error("reserved mode started");
endmodule : ebac_ctrl
`default_nettype wire

/* File: tb/ebac_host.sv */
// host core model: AXI4-Lite master issuing single register accesses
`timescale 1ns/100ps
`default_nettype none
module ebac_host (
  input  wire logic        clk,
  output var  logic [11:0] awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [11:0] araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  // ready lines stay high: a response is always taken on its first cycle
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid} = '0;
    {araddr, arvalid} = '0;
    bready = 1'b1;
    rready = 1'b1;
  end
  // calls run back to back, so an arm and its start stay in the window
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] resp);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    resp = rresp;
  endtask : rd
endmodule : ebac_host
`default_nettype wire

/* File: tb/ebac_ctrl_tb.sv */
// self-checking bench for the nonvolatile byte access controller
`timescale 1ns/100ps
`default_nettype none
module ebac_ctrl_tb;
  // short programming counts keep each operation under two dozen cycles
  localparam int AT = 8;
  localparam int ST = 4;
  localparam int DV = 2;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, stall, busy;
  int          failures = 0;
  int          compares = 0;
  int          stalls = 0;
  int          busy_cyc = 0;

  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (stall === 1'b1) stalls <= stalls + 1;
    if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
  end

  ebac_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST), .OSC_DIV(DV)) dut_u (
    .CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CPU_STALL(stall), .NV_BUSY(busy));

  ebac_host host_u (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string n, input int lo, input int hi,
                         input int g);
    compares++;
    if (g < lo || g > hi) begin
      failures++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask : chk_rng
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    host_u.wr(a, d, rsp);
  endtask : w
  task automatic r(input logic [11:0] a);
    host_u.rd(a, rdv, rsp);
  endtask : r
  task automatic wctl(input logic [1:0] m, input logic [3:0] bits);
    w(ebac_pkg::OFF_CTRL, {26'h0, m, bits});
  endtask : wctl
  task automatic set_addr(input logic [8:0] a);
    w(ebac_pkg::OFF_ADDR_LO, {24'h0, a[7:0]});
    w(ebac_pkg::OFF_ADDR_HI, {31'h0, a[8]});
  endtask : set_addr
  task automatic prog(input logic [1:0] m);
    wctl(m, 4'h0);
    wctl(m, 4'h4);
    wctl(m, 4'h2);
  endtask : prog
  task automatic wait_idle;
    do r(ebac_pkg::OFF_CTRL);
    while (rdv[ebac_pkg::CTRL_START] !== 1'b0);
  endtask : wait_idle
  task automatic pulse_rst;
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
  endtask : pulse_rst
  task automatic chk_byte(input logic [8:0] a, input logic [7:0] e);
    int s0;
    set_addr(a);
    s0 = stalls;
    wctl(2'h0, 4'h1);
    r(ebac_pkg::OFF_STALL);
    chk("stall_cnt", {29'h0, ebac_pkg::READ_STALL - 3'h1}, rdv);
    repeat (3) @(posedge clk);
    r(ebac_pkg::OFF_DATA);
    chk("read_byte", {24'h0, e}, rdv);
    chk_rng("read_stall", 4, 4, stalls - s0);
  endtask : chk_byte
  // the probe tries a mode change and a second start while busy
  task automatic prog_chk(input logic [1:0] m, input int t, input bit pr);
    int s0;
    int b0;
    s0 = stalls;
    b0 = busy_cyc;
    prog(m);
    if (pr) begin
      wctl(2'h1, 4'h6);
      r(ebac_pkg::OFF_CTRL);
      chk("mode_held", {26'h0, m, 4'h2}, rdv & 32'h32);
    end
    wait_idle();
    chk_rng("busy_len", t * DV - 1, t * DV + DV + 2, busy_cyc - b0);
    chk_rng("write_stall", 2, 2, stalls - s0);
  endtask : prog_chk
  task automatic print_verdict;
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    r(ebac_pkg::OFF_CTRL);
    chk("ctrl_reset", 32'h0, rdv);
    r(12'h014);
    chk("unmapped_rd", {30'h0, ebac_pkg::RESP_SLVERR}, {30'h0, rsp});
    w(12'h018, 32'h1);
    chk("unmapped_wr", {30'h0, ebac_pkg::RESP_SLVERR}, {30'h0, rsp});
    set_addr(9'h15A);
    w(ebac_pkg::OFF_DATA, 32'hC3);
    prog_chk(ebac_pkg::MODE_ATOMIC, AT, 1'b1);
    chk_byte(9'h15A, 8'hC3);
    prog_chk(ebac_pkg::MODE_ERASE, ST, 1'b0);
    chk_byte(9'h15A, ebac_pkg::ERASED_BYTE);
    w(ebac_pkg::OFF_DATA, 32'h3C);
    prog_chk(ebac_pkg::MODE_WRITE, ST, 1'b0);
    chk_byte(9'h15A, 8'h3C);
    set_addr(9'h05A);
    w(ebac_pkg::OFF_DATA, 32'h81);
    prog_chk(ebac_pkg::MODE_ATOMIC, AT, 1'b0);
    chk_byte(9'h05A, 8'h81);
    chk_byte(9'h15A, 8'h3C);
    // a start after the arm has lapsed must not program
    wctl(2'h0, 4'h4);
    repeat (8) @(posedge clk);
    wctl(2'h0, 4'h2);
    repeat (2) @(posedge clk);
    chk("late_start", 32'h0, {31'h0, busy});
    prog(ebac_pkg::MODE_RESV);
    repeat (2) @(posedge clk);
    chk("resv_start", 32'h0, {31'h0, busy});
    wctl(ebac_pkg::MODE_ERASE, 4'h0);
    pulse_rst();
    r(ebac_pkg::OFF_CTRL);
    chk("mode_reset", 32'h0, rdv & 32'h30);
    set_addr(9'h05A);
    prog(ebac_pkg::MODE_ERASE);
    pulse_rst();
    r(ebac_pkg::OFF_CTRL);
    chk("mode_kept_busy", 32'h12, rdv & 32'h32);
    wait_idle();
    chk_byte(9'h05A, ebac_pkg::ERASED_BYTE);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule : ebac_ctrl_tb
`default_nettype wire
